/* core/etw_timer.sv */
// Purpose: eight-bit timer with one compare channel and waveform pin
// Assumes: io strobes, compare writes and pins are synchronous to core_clk
// Notes: control register on the io port; other state on plain ports
`timescale 1ns/100ps
`include "etw_defines.svh"
module etw_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // io register port
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // compare value write and counter view
   input wire logic cmp_wr,
   input wire logic [7:0] cmp_wdata,
   output logic [7:0] count_value,
   // flags and their clears
   output logic overflow_flag,
   output logic match_flag,
   input wire logic overflow_clr,
   input wire logic match_clr,
   // external count input
   input wire logic external_count_input,
   // pin
   input wire logic port_data,
   input wire logic port_dir_out,
   output logic pin_out,
   output logic pin_oe_n
);

   // true for the two pulse modes
   function automatic logic etw_is_pwm(input logic [1:0] m);
      etw_is_pwm = m[0];
   endfunction : etw_is_pwm

   // true when the low n bits of the prescaler are all ones; never when stopped, on an external falling edge for the external selects
   function automatic logic etw_div_hit(input logic [9:0] pre, input logic [2:0] cs,
                                        input logic ext_fall);
      case (cs)
         etw_pkg::ETW_CS_STOP: etw_div_hit = 1'b0;
         etw_pkg::ETW_CS_DIV1: etw_div_hit = 1'b1;
         etw_pkg::ETW_CS_DIV8: etw_div_hit = &pre[2:0];
         etw_pkg::ETW_CS_DIV64: etw_div_hit = &pre[5:0];
         etw_pkg::ETW_CS_DIV256: etw_div_hit = &pre[7:0];
         etw_pkg::ETW_CS_DIV1024: etw_div_hit = &pre[9:0];
         default: etw_div_hit = ext_fall;
      endcase
   endfunction : etw_div_hit

   logic [6:0] ctrl;
   logic [9:0] pre;
   logic ext_prev;
   logic down;
   logic [7:0] cmp_buf;
   logic [7:0] cmp_act;
   logic wave;

   // control field decode
   wire etw_pkg::etw_mode_t mode = etw_pkg::etw_mode_t'({ctrl[`ETW_WGM_HIGH_BIT],
                                                         ctrl[`ETW_WGM_LOW_BIT]});
   wire [1:0] com = ctrl[`ETW_COM_HI_BIT:`ETW_COM_LO_BIT];
   wire [2:0] cs = ctrl[`ETW_CS_HI_BIT:0];
   wire ctrl_wr = io_wr && (io_addr == `ETW_CTRL_ADDR);
   wire [1:0] new_mode = {io_wdata[`ETW_WGM_HIGH_BIT], io_wdata[`ETW_WGM_LOW_BIT]};
   wire [1:0] new_com = io_wdata[`ETW_COM_HI_BIT:`ETW_COM_LO_BIT];

   wire ext_fall = ext_prev && !external_count_input;
   wire tick = etw_div_hit(pre, cs, ext_fall);

   // counter position decode
   wire at_max = (count_value == `ETW_MAX);
   wire at_bottom = (count_value == `ETW_BOTTOM);
   wire is_match = tick && (count_value == cmp_act);
   wire pc_mode = (mode == etw_pkg::ETW_PHASE);
   wire pc_top = tick && pc_mode && !down && at_max;
   wire wrap = tick && !pc_mode && at_max;
   wire force_cmp = ctrl_wr && io_wdata[`ETW_FORCE_BIT] && !etw_is_pwm(new_mode);

   // phase mode: 255 up plus 255 down ticks
   logic [7:0] next_count;
   logic next_down;
   always_comb begin
      next_count = count_value;
      next_down = down;
      if (tick) begin
         case (mode)
            etw_pkg::ETW_PHASE: begin
               if (!down && at_max) begin
                  next_count = `ETW_MAX_LESS1;
                  next_down = 1'b1;
               end else if (down && at_bottom) begin
                  next_count = `ETW_BOTTOM_PLUS1;
                  next_down = 1'b0;
               end else if (down) begin
                  next_count = count_value - 8'h01;
               end else begin
                  next_count = count_value + 8'h01;
               end
            end
            etw_pkg::ETW_CLEAR_ON_MATCH: begin
               next_down = 1'b0;
               next_count = (count_value == cmp_act) ? `ETW_BOTTOM : count_value + 8'h01;
            end
            default: begin
               next_down = 1'b0;
               next_count = count_value + 8'h01;
            end
         endcase
      end
   end

   // phase mode: compare loaded at TOP acts at TOP
   // fast mode: compare loaded at TOP acts from BOTTOM
   logic next_wave;
   always_comb begin
      next_wave = wave;
      case (force_cmp ? etw_pkg::ETW_NORMAL : mode) // force takes non-PWM path
         etw_pkg::ETW_PHASE: begin
            if (com[1]) begin
               if (pc_top) begin
                  next_wave = (cmp_buf == `ETW_MAX) ? !com[0] : com[0]; // level due at TOP
               end else if (is_match && (!down || at_bottom)) begin
                  next_wave = com[0];
               end else if (is_match && down && !at_max) begin
                  next_wave = !com[0];
               end
            end
         end
         etw_pkg::ETW_FAST: begin
            if (com[1]) begin
               if (wrap) begin
                  next_wave = !com[0];
               end else if (is_match && (cmp_act != `ETW_MAX)) begin
                  next_wave = com[0];
               end
            end
         end
         default: begin
            if (is_match || force_cmp) begin
               case (force_cmp ? new_com : com)
                  2'b01: next_wave = !wave;
                  2'b10: next_wave = 1'b0;
                  2'b11: next_wave = 1'b1;
                  default: next_wave = wave;
               endcase
            end
         end
      endcase
   end

   // control register, bit 7 never stored
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= 7'h00;
      end else if (ctrl_wr) begin
         ctrl <= io_wdata[6:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         io_rdata <= `ETW_CTRL_RESET;
      end else begin
         io_rdata <= (io_rd && io_addr == `ETW_CTRL_ADDR) ? {1'b0, ctrl} : 8'h00;
      end
   end

   // prescaler and external edge detect
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre <= `ETW_PRE_RESET;
         ext_prev <= 1'b0;
      end else begin
         pre <= pre + 10'h001;
         ext_prev <= external_count_input;
      end
   end

   // counter and direction
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_value <= `ETW_BOTTOM;
         down <= 1'b0;
      end else begin
         count_value <= next_count;
         down <= next_down;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_buf <= 8'h00;
         cmp_act <= 8'h00;
      end else begin
         if (cmp_wr) begin
            cmp_buf <= cmp_wdata;
         end
         if (!etw_is_pwm(mode)) begin
            cmp_act <= cmp_wr ? cmp_wdata : cmp_buf;
         end else if (pc_top || wrap) begin
            cmp_act <= cmp_buf;
         end
      end
   end

   // overflow at BOTTOM in phase mode
   wire ovf_set = wrap || (tick && pc_mode && down && count_value == `ETW_BOTTOM_PLUS1);
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         overflow_flag <= 1'b0;
         match_flag <= 1'b0;
      end else begin
         overflow_flag <= ovf_set || (overflow_flag && !overflow_clr);
         match_flag <= is_match || (match_flag && !match_clr);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wave <= 1'b0;
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         wave <= next_wave;
         pin_out <= (com != 2'b00) ? next_wave : port_data;
         pin_oe_n <= !port_dir_out;
      end
   end

   property p_pc_turn;
      @(posedge core_clk) disable iff (!arst_n)
         pc_top |=> (count_value == `ETW_MAX_LESS1) && down;
   endproperty
   a_pc_turn: assert property (p_pc_turn) else $error("phase turn at max wrong");
   property p_pc_no_early_turn;
      @(posedge core_clk) disable iff (!arst_n)
         (tick && pc_mode && !down && !at_max && !ctrl_wr) |=> !down;
   endproperty
   a_pc_no_early_turn: assert property (p_pc_no_early_turn) else $error("early turn");
   property p_pc_bottom_flag;
      @(posedge core_clk) disable iff (!arst_n)
         (tick && pc_mode && down && count_value == `ETW_BOTTOM_PLUS1)
            |=> overflow_flag && (count_value == `ETW_BOTTOM);
   endproperty
   a_pc_bottom_flag: assert property (p_pc_bottom_flag) else $error("no bottom flag");
   property p_max_flag;
      @(posedge core_clk) disable iff (!arst_n)
         wrap |=> overflow_flag && (count_value == `ETW_BOTTOM);
   endproperty
   a_max_flag: assert property (p_max_flag) else $error("no max flag");
   property p_ctc_clear;
      @(posedge core_clk) disable iff (!arst_n)
         (mode == etw_pkg::ETW_CLEAR_ON_MATCH && is_match && !ctrl_wr)
            |=> count_value == `ETW_BOTTOM;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on match");
   property p_hold;
      @(posedge core_clk) disable iff (!arst_n)
         !tick |=> $stable(count_value);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved without tick");
   property p_flag_cause;
      @(posedge core_clk) disable iff (!arst_n)
         $rose(match_flag) |-> $past(is_match);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("flag without match");
   property p_strobe_zero;
      @(posedge core_clk) disable iff (!arst_n)
         (io_rd && io_addr == `ETW_CTRL_ADDR) |=> !io_rdata[`ETW_FORCE_BIT];
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("strobe read one");
   property p_force_toggle;
      @(posedge core_clk) disable iff (!arst_n)
         (force_cmp && new_com == 2'b01) |=> wave != $past(wave);
   endproperty
   a_force_toggle: assert property (p_force_toggle) else $error("force no toggle");
   property p_oe;
      @(posedge core_clk) disable iff (!arst_n)
         port_dir_out |=> !pin_oe_n;
   endproperty
   a_oe: assert property (p_oe) else $error("pin not driven");
endmodule : etw_timer

/* core/etw_defines.svh */
// Purpose: constants of the eight-bit timer waveform unit
// Assumes: io register space of six address bits
// Notes: definitions only
`ifndef ETW_DEFINES_SVH
`define ETW_DEFINES_SVH
`define ETW_CTRL_ADDR 6'h25
`define ETW_CTRL_RESET 8'h00
`define ETW_FORCE_BIT 7
`define ETW_WGM_LOW_BIT 6
`define ETW_COM_HI_BIT 5
`define ETW_COM_LO_BIT 4
`define ETW_WGM_HIGH_BIT 3
`define ETW_CS_HI_BIT 2
`define ETW_MAX 8'hFF
`define ETW_MAX_LESS1 8'hFE
`define ETW_BOTTOM 8'h00
`define ETW_BOTTOM_PLUS1 8'h01
`define ETW_PC_PERIOD_TICKS 510
`define ETW_PRE_RESET 10'h000
`endif

/* core/etw_pkg.sv */
// Purpose: types of the eight-bit timer waveform unit
// Assumes: constants come from etw_defines.svh
// Notes: no constants held here
package etw_pkg;
   typedef enum logic [1:0] {
      ETW_NORMAL = 2'b00,
      ETW_PHASE = 2'b01,
      ETW_CLEAR_ON_MATCH = 2'b10,
      ETW_FAST = 2'b11
   } etw_mode_t;
   typedef enum logic [2:0] {
      ETW_CS_STOP = 3'b000,
      ETW_CS_DIV1 = 3'b001,
      ETW_CS_DIV8 = 3'b010,
      ETW_CS_DIV64 = 3'b011,
      ETW_CS_DIV256 = 3'b100,
      ETW_CS_DIV1024 = 3'b101,
      ETW_CS_EXT_A = 3'b110,
      ETW_CS_EXT_B = 3'b111
   } etw_clk_sel_t;
endpackage : etw_pkg

/* dv/test_eight_bit_timer_waveform_unit.sv */
// Purpose: self-checking bench of the eight-bit timer waveform unit
// Assumes: inputs driven 10 ns after each rising edge of core_clk
// Notes: expected counts and pin levels worked out from mode and compare setup
`timescale 1ns/100ps
module test_eight_bit_timer_waveform_unit;
   // design inputs
   logic core_clk, arst_n, io_wr, io_rd, cmp_wr, overflow_clr, match_clr;
   logic external_count_input, port_data, port_dir_out;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, cmp_wdata;
   // design outputs
   logic [7:0] io_rdata, count_value;
   logic overflow_flag, match_flag, pin_out, pin_oe_n;
   // widened views for the compare task
   wire logic [15:0] cnt = {8'h00, count_value};
   wire logic [15:0] pin = {15'h0000, pin_out};
   wire logic [15:0] oen = {15'h0000, pin_oe_n};
   wire logic [15:0] mf = {15'h0000, match_flag};
   wire logic [15:0] ovf = {15'h0000, overflow_flag};
   int miscompares = 0;
   int n_compared = 0;
   int k;
   logic [15:0] rd;
   int divs[6] = '{0, 1, 8, 64, 256, 1024};
   // phase cases: compare, then {action, level rising, level falling}
   logic [7:0] pc_cmp[4] = '{8'h80, 8'h80, 8'h00, 8'hFF};
   logic [3:0] pc_tab[4] = '{4'b1001, 4'b1110, 4'b1000, 4'b1011};
   logic [7:0] frc[4] = '{8'hB0, 8'hA0, 8'h90, 8'h90};

   etw_timer dut_u (.core_clk(core_clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .cmp_wr(cmp_wr),
      .cmp_wdata(cmp_wdata), .count_value(count_value), .overflow_flag(overflow_flag),
      .match_flag(match_flag), .overflow_clr(overflow_clr), .match_clr(match_clr),
      .external_count_input(external_count_input), .port_data(port_data),
      .port_dir_out(port_dir_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

   // free running clock, 100 ns period
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   task automatic tick();
      @(posedge core_clk);
      #10;
   endtask : tick

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one step of a bounded wait, ends the run when used up
   task automatic bump();
      tick();
      k++;
      if (k > 3000) begin
         miscompares++;
         print_verdict();
      end
   endtask : bump

   task automatic io_write(input logic [5:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      tick();
      io_wr = 1'b0;
      tick();
   endtask : io_write

   task automatic io_read(input logic [5:0] a);
      io_addr = a;
      io_rd = 1'b1;
      tick();
      rd = {8'h00, io_rdata};
      io_rd = 1'b0;
      tick();
   endtask : io_read

   task automatic set_cmp(input logic [7:0] v);
      cmp_wdata = v;
      cmp_wr = 1'b1;
      tick();
      cmp_wr = 1'b0;
      tick();
   endtask : set_cmp

   task automatic wait_cnt(input logic [7:0] v);
      k = 0;
      while (count_value !== v) bump();
   endtask : wait_cnt

   task automatic wait_ovf();
      k = 0;
      while (overflow_flag !== 1'b1) bump();
   endtask : wait_ovf

   // edges between two counter changes, left in k
   task automatic gap();
      rd = cnt;
      k = 0;
      while (cnt === rd) bump();
   endtask : gap

   task automatic clr_ovf();
      overflow_clr = 1'b1;
      tick();
      overflow_clr = 1'b0;
   endtask : clr_ovf

   task automatic wave(input logic [7:0] c, input logic e);
      wait_cnt(c);
      tick();
      chk(pin, {15'h0000, e});
   endtask : wave

   // main sequence
   initial begin
      {arst_n, io_wr, io_rd, cmp_wr, overflow_clr, match_clr} = 6'h00;
      {external_count_input, port_data, port_dir_out} = 3'b100;
      io_addr = 6'h00;
      io_wdata = 8'h00;
      cmp_wdata = 8'h00;
      repeat (8) @(posedge core_clk);
      #10 arst_n = 1'b1;
      tick();
      io_read(6'h25);
      chk(rd, 16'h0000);
      chk(oen, 16'h0001);
      chk(cnt, 16'h0000);
      io_write(6'h25, 8'hFF);
      io_read(6'h25);
      chk(rd, 16'h007F);
      chk(pin, 16'h0000);
      io_read(6'h24);
      chk(rd, 16'h0000);
      // prescaler divisors in normal mode
      for (int i = 1; i < 6; i++) begin
         io_write(6'h25, {5'h00, 3'(i)});
         gap();
         gap();
         chk(16'(k), 16'(divs[i]));
      end
      io_write(6'h25, 8'h01);
      clr_ovf();
      wait_ovf();
      chk(cnt, 16'h0000);
      // clear on match wraps at the compare value
      io_write(6'h25, 8'h00);
      set_cmp(8'h10);
      io_write(6'h25, 8'h19);
      wait_cnt(8'h10);
      tick();
      chk(cnt, 16'h0000);
      chk(pin, 16'h0001);
      tick();
      chk(mf, 16'h0001);
      io_write(6'h25, 8'h00);
      match_clr = 1'b1;
      tick();
      match_clr = 1'b0;
      tick();
      chk(mf, 16'h0000);
      // forced matches: set, clear, toggle twice
      port_dir_out = 1'b1;
      for (int i = 0; i < 4; i++) begin
         io_write(6'h25, frc[i]);
         tick();
         chk(pin, {15'h0000, (i % 2 == 0)});
         chk(mf, 16'h0000);
      end
      chk(oen, 16'h0000);
      io_write(6'h25, 8'h00);
      port_data = 1'b1;
      tick();
      tick();
      chk(pin, 16'h0001);
      port_dir_out = 1'b0;
      tick();
      tick();
      chk(oen, 16'h0001);
      // fast mode, non-inverting then inverting
      set_cmp(8'h80);
      for (int i = 2; i < 4; i++) begin
         io_write(6'h25, {2'b01, 2'(i), 4'b1001});
         wave(8'h90, i[0]);
         wave(8'h10, !i[0]);
      end
      // phase mode cases
      for (int i = 0; i < 4; i++) begin
         io_write(6'h25, 8'h00);
         set_cmp(pc_cmp[i]);
         io_write(6'h25, {2'b01, pc_tab[i][3:2], 4'b0001});
         wait_cnt(8'hFF);
         tick();
         chk(cnt, 16'h00FE);
         wait_cnt(8'h01);
         wave(8'h90, pc_tab[i][1]);
         wave(8'h70, pc_tab[i][0]);
      end
      // compare leaves MAX: level at TOP is the up-count result
      set_cmp(8'h80);
      wave(8'hFF, 1'b0);
      wave(8'h70, 1'b1);
      clr_ovf();
      chk(ovf, 16'h0000);
      wait_ovf();
      chk(cnt, 16'h0000);
      clr_ovf();
      wait_ovf();
      // one edge of the period is spent in the clear pulse
      chk(16'(k), 16'(510 - 1));
      // external falling edges advance the count
      for (int i = 6; i < 8; i++) begin
         io_write(6'h25, {5'h00, 3'(i)});
         rd = cnt;
         repeat (3) begin
            external_count_input = 1'b0;
            tick();
            tick();
            external_count_input = 1'b1;
            tick();
            tick();
         end
         chk(cnt, rd + 16'h0003);
      end
      print_verdict();
   end
endmodule : test_eight_bit_timer_waveform_unit
